// *** lif_pkg.sv ***
package lif_pkg;

  // ------------------------------------------------------------------
  // selector encoding: 0 disabled, 1..20 logic input number
  // ------------------------------------------------------------------
  localparam int unsigned NUM_INPUTS     = 20;
  localparam int unsigned SEL_W          = 5;
  localparam logic [4:0]  SEL_DISABLED   = 5'h00;
  localparam logic [4:0]  SEL_FIRST      = 5'h01;
  localparam logic [4:0]  SEL_LAST       = 5'h14;
  localparam int unsigned CONTACT_INPUTS = 14;   // inputs 15..20 are virtual only

  // ------------------------------------------------------------------
  // function indices (one selector register each)
  // ------------------------------------------------------------------
  localparam int unsigned F_BLK_TRIP     = 0;
  localparam int unsigned F_BLK_CLOSE    = 1;
  localparam int unsigned F_BLK_RESET    = 2;
  localparam int unsigned F_BLK_UV1      = 3;
  localparam int unsigned F_BLK_UV2      = 4;
  localparam int unsigned F_BLK_UV3      = 5;
  localparam int unsigned F_BLK_UV4      = 6;
  localparam int unsigned F_BLK_UF1      = 7;
  localparam int unsigned F_BLK_UF2      = 8;
  localparam int unsigned F_BLK_DECAY    = 9;
  localparam int unsigned F_SYNC_BYPASS  = 10;
  localparam int unsigned F_STAT_INH     = 11;
  localparam int unsigned F_BLK_NSV      = 12;
  localparam int unsigned F_BLK_NDISP    = 13;
  localparam int unsigned F_BLK_RESTORE  = 14;
  localparam int unsigned F_REVP_INH     = 15;
  localparam int unsigned F_OC_ALL       = 16;
  localparam int unsigned F_OC_PHASE     = 17;
  localparam int unsigned F_OC_NEUTRAL   = 18;
  localparam int unsigned F_OC_GND       = 19;
  localparam int unsigned F_OC_SGND      = 20;
  localparam int unsigned F_OC_STAGE0    = 21;   // 14 stages follow
  localparam int unsigned OC_STAGES      = 14;
  localparam int unsigned F_INC1_CLOSED  = 35;
  localparam int unsigned F_INC2_CLOSED  = 36;
  localparam int unsigned F_INC1_CLOSEREQ= 37;
  localparam int unsigned F_INC2_CLOSEREQ= 38;
  localparam int unsigned F_TIE_CONN     = 39;
  localparam int unsigned F_TIE_CLOSED   = 40;
  localparam int unsigned F_XFMR_LOCK1   = 41;
  localparam int unsigned F_XFMR_LOCK2   = 42;
  localparam int unsigned F_SRC_TRIP1    = 43;
  localparam int unsigned F_SRC_TRIP2    = 44;
  localparam int unsigned F_XFER_INH     = 45;
  localparam int unsigned F_RCL_START    = 46;
  localparam int unsigned F_RCL_CANCEL   = 47;
  localparam int unsigned F_RCL_INH      = 48;
  localparam int unsigned F_FAULT_SIM    = 49;
  localparam int unsigned NUM_FUNCS      = 50;

  // ------------------------------------------------------------------
  // register map: selector n at byte SEL_BASE + 4*n, status after
  // ------------------------------------------------------------------
  localparam logic [7:0] SEL_BASE        = 8'h00;
  localparam logic [7:0] STATUS_IN_ADDR  = 8'hd0;
  localparam logic [7:0] STATUS_SIM_ADDR = 8'hd4;
  localparam logic [4:0] SEL_RESET_VAL   = 5'h00;

  typedef enum logic [1:0] {LIF_SIM_OFF, LIF_SIM_PREFAULT, LIF_SIM_FAULT} lif_sim_e;

endpackage : lif_pkg

// *** lif_sel_if.sv ***
`timescale 1ns/1ps
// selector bank to decoder: settings and resulting function levels
interface lif_sel_if;
  import lif_pkg::*;
  logic [SEL_W-1:0]    sel [NUM_FUNCS];
  logic [NUM_FUNCS-1:0] func;
  modport bank (output sel, input func);
  modport dec  (input sel, output func);
endinterface : lif_sel_if

// *** lif_decode.sv ***
`timescale 1ns/1ps
// maps each selector onto the asserted logic inputs
module lif_decode
  import lif_pkg::*;
(
  input  wire logic [NUM_INPUTS-1:0] logic_in_i,
  lif_sel_if.dec                     sel_if
);
  import lif_pkg::*;

  // ------------------------------------------------------------------
  // selection function
  // ------------------------------------------------------------------
  function automatic logic pick(input logic [SEL_W-1:0] s,
                                input logic [NUM_INPUTS-1:0] v);
    logic r;
    r = 1'b0;
    if (s >= SEL_FIRST && s <= SEL_LAST)   // disabled or out of range never fires
      r = v[s - SEL_FIRST];
    return r;
  endfunction : pick

  // ------------------------------------------------------------------
  // one decoder per function, same cycle
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_FUNCS; g++)
    begin : g_fn
      assign sel_if.func[g] = pick(sel_if.sel[g], logic_in_i);
    end
  endgenerate

endmodule : lif_decode

// *** lif_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - each function selector names input 1..20 or is disabled; disabled never fires
// - blocked elements stop detect, message, indicate; trip block gates only trip relay
// - assigned close-supervision input must be deasserted for close relay to operate
// - synchrocheck override asserted allows closing without synchrocheck
// - statistics inhibit stops operation count, trip count, arcing accumulation
// - reverse-power block selector exists only with its feature option enabled
// - separate blocks for all, group (none for nseq stages) and individual overcurrent stages
// - incomer and tie closed inputs give breaker state to transfer logic
// - close request from either incomer starts tie breaker close
// - tie breaker not connected inhibits transfers
// - xfmr_lockout_initiate_select or source trip initiates transfer away from source
// - transfer inhibit disables whole transfer scheme
// - reclose start begins sequence to close, never operating trip relay
// - reclose cancel or inhibit aborts sequence and blocks autoreclose
// - fault simulation only in test mode, breaker closed, prefault state
// - accepted fault simulation moves to fault state, applies fault values
// - selected input asserted invokes function; one input may drive many
// - inputs 15..20 come only from virtual inputs
module lif_top
  import lif_pkg::*;
#(
  parameter bit REVP_OPTION = 1'b0
)
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone classic slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [7:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  // combined logic inputs from the input combiner
  input  wire logic [NUM_INPUTS-1:0]    logic_in_i,
  input  wire logic [NUM_INPUTS-1:0]    logic_in_contact_i,
  // element requests
  input  wire logic                     trip_req_i,
  input  wire logic                     close_req_i,
  input  wire logic                     sync_ok_i,
  input  wire logic                     stat_update_i,
  input  wire logic                     sim_test_mode_i,
  input  wire logic                     sim_brkr_closed_i,
  input  wire logic                     sim_restore_i,
  // gated results
  output logic                          trip_relay_o,
  output logic                          close_relay_o,
  output logic                          reset_block_o,
  output logic [10:0]                   prot_block_o,
  output logic                          revp_block_o,
  output logic [OC_STAGES-1:0]          oc_stage_block_o,
  output logic                          stat_update_o,
  output logic                          inc1_closed_o,
  output logic                          inc2_closed_o,
  output logic                          tie_closed_o,
  output logic                          tie_close_start_o,
  output logic                          xfer_enable_o,
  output logic                          xfer_from_src1_o,
  output logic                          xfer_from_src2_o,
  output logic                          reclose_start_o,
  output logic                          reclose_abort_o,
  output logic                          sim_fault_apply_o,
  output logic [1:0]                    sim_state_o
);
  import lif_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_FUNCS-1:0][SEL_W-1:0] sel;
    logic                             ack;
    logic [31:0]                      rdat;
    lif_sim_e                         sim;
  } lif_state_s;

  lif_state_s st_q;
  lif_state_s st_d;

  lif_sel_if sel_if ();
  logic [NUM_INPUTS-1:0] eff_in;
  logic [NUM_FUNCS-1:0]  f;
  logic                  oc_all;
  logic                  oc_grp [4];
  logic                  wr_hit;
  logic                  rd_cyc;
  logic [5:0]            widx;
  logic                  bus_req;
  logic                  sel_word;
  logic [31:0]           status_in_w;
  logic [31:0]           status_sim_w;
  logic                  sim_arm;
  logic                  close_permit;
  logic                  inc_close_req;
  logic                  src1_loss;
  logic                  src2_loss;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // word index that lands on a selector register
  function automatic logic is_sel_word(input logic [5:0] idx);
    return idx < 6'(NUM_FUNCS);
  endfunction : is_sel_word

  // value kept for a selector write; illegal or absent selectors read back disabled
  function automatic logic [SEL_W-1:0] sel_store(input logic [5:0]       idx,
                                                 input logic [SEL_W-1:0] val);
    logic [SEL_W-1:0] r;
    r = val;
    if (idx == 6'(F_REVP_INH) && !REVP_OPTION)
      r = SEL_DISABLED;
    else if (val > SEL_LAST)
      r = SEL_DISABLED;
    return r;
  endfunction : sel_store

  // ------------------------------------------------------------------
  // virtual-only inputs above the contact range
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_in
      if (gi < CONTACT_INPUTS)
      begin : g_c
        assign eff_in[gi] = logic_in_i[gi];
      end
      else
      begin : g_v
        assign eff_in[gi] = logic_in_i[gi] & ~logic_in_contact_i[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // selectors to decoder
  // ------------------------------------------------------------------
  genvar gs;
  generate
    for (gs = 0; gs < NUM_FUNCS; gs++)
    begin : g_sel
      assign sel_if.sel[gs] = st_q.sel[gs];
    end
  endgenerate

  lif_decode u_dec (
    .logic_in_i (eff_in),
    .sel_if     (sel_if)
  );
  assign f = sel_if.func;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign widx     = adr_i[7:2];
  assign sel_word = is_sel_word(widx);
  assign bus_req  = cyc_i & stb_i & ~st_q.ack;   // fresh request, not the ack cycle
  assign wr_hit   = bus_req & we_i & sel_i[0] & sel_word;
  assign rd_cyc   = bus_req & ~we_i;

  // status words for the read path
  assign status_in_w  = {12'h000, eff_in};
  assign status_sim_w = {30'h0, st_q.sim};

  // fault simulation arms only with the breaker closed
  assign sim_arm      = f[F_FAULT_SIM] & sim_brkr_closed_i;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    st_d.ack = bus_req;                     // one wait state, ack one cycle
    if (wr_hit)
      st_d.sel[widx] = sel_store(widx, dat_i[SEL_W-1:0]);
    if (rd_cyc)
    begin
      st_d.rdat = 32'h0000_0000;
      if (is_sel_word(widx))
        st_d.rdat = {27'h0, st_q.sel[widx]};
      else if (adr_i == STATUS_IN_ADDR)
        st_d.rdat = status_in_w;
      else if (adr_i == STATUS_SIM_ADDR)
        st_d.rdat = status_sim_w;
    end
    // fault simulation state
    unique case (st_q.sim)
      LIF_SIM_OFF:
        if (sim_test_mode_i)
          st_d.sim = LIF_SIM_PREFAULT;
      LIF_SIM_PREFAULT:
        if (!sim_test_mode_i)
          st_d.sim = LIF_SIM_OFF;
        else if (sim_arm)
          st_d.sim = LIF_SIM_FAULT;
      LIF_SIM_FAULT:
        if (!sim_test_mode_i)
          st_d.sim = LIF_SIM_OFF;
        else if (sim_restore_i)
          st_d.sim = LIF_SIM_PREFAULT;
      default:
        st_d.sim = LIF_SIM_OFF;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q      <= '0;
      st_q.sim  <= LIF_SIM_OFF;
    end
    else
      st_q <= st_d;
  end

  assign ack_o = st_q.ack;
  assign dat_o = st_q.rdat;

  // ------------------------------------------------------------------
  // protection and relay gating
  // ------------------------------------------------------------------
  // close needs supervision clear and synchrocheck met or bypassed
  assign close_permit  = ~f[F_BLK_CLOSE]
                         & (sync_ok_i | f[F_SYNC_BYPASS]);

  // trip block touches the trip relay only
  assign trip_relay_o  = trip_req_i & ~f[F_BLK_TRIP];
  assign close_relay_o = close_req_i & close_permit;
  assign reset_block_o = f[F_BLK_RESET];
  assign prot_block_o  = {f[F_BLK_RESTORE], f[F_BLK_NDISP], f[F_BLK_NSV],
                          f[F_BLK_DECAY], f[F_BLK_UF2], f[F_BLK_UF1],
                          f[F_BLK_UV4], f[F_BLK_UV3], f[F_BLK_UV2],
                          f[F_BLK_UV1], 1'b0};
  assign revp_block_o  = REVP_OPTION & f[F_REVP_INH];
  assign stat_update_o = stat_update_i & ~f[F_STAT_INH];

  // overcurrent: stages 0..3 phase, 4..7 neutral, 8..9 gnd, 10..11 sgnd, 12..13 nseq
  assign oc_all    = f[F_OC_ALL];
  assign oc_grp[0] = f[F_OC_PHASE];
  assign oc_grp[1] = f[F_OC_NEUTRAL];
  assign oc_grp[2] = f[F_OC_GND];
  assign oc_grp[3] = f[F_OC_SGND];
  genvar go;
  generate
    for (go = 0; go < OC_STAGES; go++)
    begin : g_oc
      if (go < 4)
      begin : g_p
        assign oc_stage_block_o[go] = oc_all | oc_grp[0] | f[F_OC_STAGE0+go];
      end
      else if (go < 8)
      begin : g_n
        assign oc_stage_block_o[go] = oc_all | oc_grp[1] | f[F_OC_STAGE0+go];
      end
      else if (go < 10)
      begin : g_g
        assign oc_stage_block_o[go] = oc_all | oc_grp[2] | f[F_OC_STAGE0+go];
      end
      else if (go < 12)
      begin : g_s
        assign oc_stage_block_o[go] = oc_all | oc_grp[3] | f[F_OC_STAGE0+go];
      end
      else
      begin : g_q
        assign oc_stage_block_o[go] = oc_all | f[F_OC_STAGE0+go];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // bus transfer
  // ------------------------------------------------------------------
  assign inc1_closed_o     = f[F_INC1_CLOSED];
  assign inc2_closed_o     = f[F_INC2_CLOSED];
  assign tie_closed_o      = f[F_TIE_CLOSED];
  assign xfer_enable_o     = ~f[F_XFER_INH] & f[F_TIE_CONN];

  // transfer initiators, gated by the scheme enable
  assign inc_close_req     = f[F_INC1_CLOSEREQ] | f[F_INC2_CLOSEREQ];
  assign src1_loss         = f[F_XFMR_LOCK1] | f[F_SRC_TRIP1];
  assign src2_loss         = f[F_XFMR_LOCK2] | f[F_SRC_TRIP2];
  assign tie_close_start_o = xfer_enable_o & inc_close_req;
  assign xfer_from_src1_o  = xfer_enable_o & src1_loss;
  assign xfer_from_src2_o  = xfer_enable_o & src2_loss;

  // ------------------------------------------------------------------
  // autoreclose and simulation
  // ------------------------------------------------------------------
  assign reclose_abort_o   = f[F_RCL_CANCEL] | f[F_RCL_INH];
  assign reclose_start_o   = f[F_RCL_START] & ~reclose_abort_o;
  assign sim_fault_apply_o = (st_q.sim == LIF_SIM_FAULT);
  assign sim_state_o       = st_q.sim;

endmodule : lif_top

// *** lif_sva.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port watcher for the selector block
// ------------------------------------------------------------
module lif_sva
  import lif_pkg::*;
#(
  parameter bit REVP_OPTION = 1'b0
)
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        trip_req_i,
  input wire logic        close_req_i,
  input wire logic        stat_update_i,
  input wire logic        sim_test_mode_i,
  input wire logic        sim_brkr_closed_i,
  input wire logic        trip_relay_o,
  input wire logic        close_relay_o,
  input wire logic        stat_update_o,
  input wire logic        revp_block_o,
  input wire logic [10:0] prot_block_o,
  input wire logic        xfer_enable_o,
  input wire logic        sim_fault_apply_o,
  input wire logic [1:0]  sim_state_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answer timing
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  // gated outputs never exceed their requests
  trip_gate_a: assert property (trip_relay_o |-> trip_req_i)
    else $error("trip without request");
  close_gate_a: assert property (close_relay_o |-> close_req_i)
    else $error("close without request");
  stat_gate_a: assert property (stat_update_o |-> stat_update_i)
    else $error("statistics update without request");
  revp_opt_a: assert property (REVP_OPTION || !revp_block_o)
    else $error("reverse power block without option");
  // disabled selectors after reset pass trip requests unchanged, no protection block, no transfer enable
  rst_clear_a: assert property ($past(rst_i) |-> trip_relay_o == trip_req_i
    && prot_block_o == 11'h0 && !xfer_enable_o)
    else $error("function active after reset");
  // simulation state moves
  sim_enter_a: assert property (sim_state_o == 2'h2 && $past(sim_state_o) == 2'h1
    |-> $past(sim_test_mode_i && sim_brkr_closed_i))
    else $error("fault state entered without conditions");
  sim_off_a: assert property (!sim_test_mode_i |=> sim_state_o == 2'h0)
    else $error("simulation left on outside test mode");
  sim_apply_a: assert property (sim_fault_apply_o |-> sim_state_o == 2'h2)
    else $error("fault values applied outside fault state");
endmodule : lif_sva

// *** lif_partner.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// input combiner stand-in
// ------------------------------------------------------------
module lif_partner
  import lif_pkg::*;
(
  input  wire logic [NUM_INPUTS-1:0] virt_i,
  input  wire logic [NUM_INPUTS-1:0] cont_i,
  output logic      [NUM_INPUTS-1:0] logic_in_o,
  output logic      [NUM_INPUTS-1:0] contact_o
);
  // inputs 1..14 mix contact and virtual, 15..20 virtual only
  assign logic_in_o = virt_i | (cont_i & 20'h03fff);
  assign contact_o  = cont_i;
endmodule : lif_partner

// *** lif_tb.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench for the selector block
// ------------------------------------------------------------
module testbench;
  import lif_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, trip_req_i, close_req_i, sync_ok_i;
  logic        stat_update_i, sim_test_mode_i, sim_brkr_closed_i, sim_restore_i, ack_o;
  logic        trip_relay_o, close_relay_o, reset_block_o, revp_block_o, stat_update_o;
  logic        inc1_closed_o, inc2_closed_o, tie_closed_o, tie_close_start_o;
  logic        xfer_enable_o, xfer_from_src1_o, xfer_from_src2_o, reclose_start_o;
  logic        reclose_abort_o, sim_fault_apply_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q, r;
  logic [10:0] prot_block_o;
  logic [13:0] oc_stage_block_o;
  logic [1:0]  sim_state_o;
  logic [19:0] logic_in_i, logic_in_contact_i, virt, cont, eff_m;
  logic [3:0]  steps [6] = '{4'b1000, 4'b1001, 4'b1101, 4'b1010, 4'b1101, 4'b0100};
  int          sel_m [NUM_FUNCS];
  int          sim_m, f, cycles, miscompares, check_count;

  lif_top #(.REVP_OPTION(1'b0)) dut (.*);
  lif_partner u_partner (.virt_i(virt), .cont_i(cont), .logic_in_o(logic_in_i),
                         .contact_o(logic_in_contact_i));

  // reference model of effective inputs and simulation state
  assign eff_m = (virt | (cont & 20'h03fff)) & ~(cont & 20'hfc000);
  function automatic logic ef(input int n);
    return sel_m[n] != 0 && eff_m[sel_m[n] - 1];
  endfunction : ef
  always @(posedge clk_i)
    if (rst_i || !sim_test_mode_i) sim_m <= 0;
    else if (sim_m == 0) sim_m <= 1;
    else if (sim_m == 1 && ef(F_FAULT_SIM) && sim_brkr_closed_i) sim_m <= 2;
    else if (sim_m == 2 && sim_restore_i) sim_m <= 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test;
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    cmp(g, e);
  endtask : chk_rd
  task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
    cmp(g, e);
  endtask : chk_out

  // classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)   // only the cycle guard ends a hang
      @(posedge clk_i);
    q = dat_o;
    if (w && a < 8'hc8)
      sel_m[a >> 2] <= (d[4:0] > 5'h14 || (a >> 2) == F_REVP_INH) ? 0 : d[4:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic check_outs;
    logic [13:0] oc;
    logic        xe;
    for (int s = 0; s < 14; s++)
      oc[s] = ef(16) || (s < 12 && ef(s < 4 ? 17 : s < 8 ? 18 : s < 10 ? 19 : 20)) || ef(21 + s);
    xe = ef(F_TIE_CONN) && !ef(F_XFER_INH);
    chk_out(trip_relay_o, trip_req_i && !ef(0));
    chk_out(close_relay_o, close_req_i && !ef(1) && (sync_ok_i || ef(10)));
    chk_out(reset_block_o, ef(2));
    chk_out(prot_block_o, {ef(14), ef(13), ef(12), ef(9), ef(8), ef(7), ef(6), ef(5),
                           ef(4), ef(3), 1'b0});
    chk_out(revp_block_o, 1'b0);
    chk_out(oc_stage_block_o, oc);
    chk_out(stat_update_o, stat_update_i && !ef(11));
    chk_out({inc1_closed_o, inc2_closed_o, tie_closed_o}, {ef(35), ef(36), ef(40)});
    chk_out(tie_close_start_o, xe && (ef(37) || ef(38)));
    chk_out(xfer_enable_o, xe);
    chk_out({xfer_from_src1_o, xfer_from_src2_o},
            {xe && (ef(41) || ef(43)), xe && (ef(42) || ef(44))});
    chk_out({reclose_start_o, reclose_abort_o},
            {ef(46) && !ef(47) && !ef(48), ef(47) || ef(48)});
    chk_out(sim_state_o, sim_m[1:0]);
    chk_out(sim_fault_apply_o, sim_m == 2);
  endtask : check_outs

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    {cyc_i, stb_i, we_i, trip_req_i, close_req_i, sync_ok_i, stat_update_i} = 7'h0;
    {sim_test_mode_i, sim_brkr_closed_i, sim_restore_i, adr_i, dat_i} = 43'h0;
    {virt, cont, sel_i, sim_m, cycles, miscompares, check_count} = 0;
    sel_i = 4'hf;
    r = 32'h938f1010;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_outs;
    for (int n = 0; n < NUM_FUNCS; n++)
    begin
      wb(1'b0, 8'(4 * n), 32'h0);
      chk_rd(q, 32'h0);
    end
    wb(1'b1, 8'hd8, 32'h5);
    wb(1'b0, 8'hd8, 32'h0);
    chk_rd(q, 32'h0);
    $display("reset and map test done");
    for (int i = 0; i < 300; i++)
    begin
      r = lfsr(r);
      f = r[13:8] % NUM_FUNCS;
      wb(1'b1, 8'(4 * f), {27'h0, r[4:0]});
      wb(1'b0, 8'(4 * f), 32'h0);
      chk_rd(q, sel_m[f]);
      r = lfsr(r);
      virt <= r[19:0];
      {trip_req_i, close_req_i, sync_ok_i, stat_update_i} <= r[23:20];
      r = lfsr(r);
      cont <= r[19:0] & r[31:12];
      @(posedge clk_i);
      check_outs;
      wb(1'b0, STATUS_IN_ADDR, 32'h0);
      chk_rd(q, {12'h0, eff_m});
    end
    $display("random selector test done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    sel_m = '{default: 0};
    @(posedge clk_i);
    check_outs;
    wb(1'b0, 8'(4 * F_OC_ALL), 32'h0);
    chk_rd(q, 32'h0);
    wb(1'b1, 8'(4 * F_FAULT_SIM), 32'h3);
    cont <= 20'h0;
    for (int k = 0; k < 6; k++)
    begin
      {sim_test_mode_i, sim_brkr_closed_i, sim_restore_i} <= steps[k][3:1];
      virt <= {17'h0, steps[k][0], 2'h0};
      repeat (2) @(posedge clk_i);
      check_outs;
      wb(1'b0, STATUS_SIM_ADDR, 32'h0);
      chk_rd(q, sim_m);
    end
    $display("fault simulation test done");
    finish_test;
  end
endmodule : testbench

bind lif_top lif_sva #(.REVP_OPTION(REVP_OPTION)) u_sva (.*);
